// >>> rtl/i2c_slave_gpio_regs.sv
// What this block does
// - Control bits set each pin's direction
// - Output pins drive their data bits
// - PWM enable forces pin 0 input
// - Only pin 0 offers PWM input
// - Data read returns actual pin levels
// - Data changes only while clock low
// - Detect START and STOP while clock high
// - Bus busy from START until STOP
// - Repeated START restarts address reception
// - Bytes are eight bits, MSB first
// - Receiver pulls data low on ninth
// - Addressed slave acknowledges every received byte
// - Address 59H plus direction bit
// - Write sends index then data byte
// - Write applies at each data acknowledge rise
`timescale 1ns/1ps
`include "gpio_i2c_map.svh"
module i2c_slave_gpio_regs
  import gpio_i2c_pkg::*;
(
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe_b_o,
  input  wire logic [`PIN_COUNT-1:0] gpio_i,
  output logic      [`PIN_COUNT-1:0] gpio_o,
  output logic      [`PIN_COUNT-1:0] gpio_oe_b_o,
  output logic                       pwm_in_o,
  output logic                       bus_busy_o
);
  logic [1:0] scl_sync_q, sda_sync_q;
  logic       scl_q, sda_q;
  logic       scl_rise, scl_fall, start_det, stop_det;

  slave_state_e state_q, state_d;
  logic [3:0]   bit_cnt_q, bit_cnt_d;
  byte_t        shift_q, shift_d;
  byte_t        index_q, index_d;
  logic         ack_drv_q, ack_drv_d;
  logic         tx_bit_q, tx_bit_d;
  logic         busy_q, busy_d;
  logic         phase_q, phase_d;
  logic         wr_en;
  byte_t        rd_data, pin_control, pin_data;

  logic [`PIN_COUNT-1:0] gpio_sync1_q, gpio_sync2_q;
  logic [`PIN_COUNT-1:0] oe_q, oe_d, out_q, out_d;
  logic                  pwm_q, pwm_d;

  // Synchronise pins; stage one is read only by stage two
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      scl_sync_q   <= 2'h3;
      sda_sync_q   <= 2'h3;
      scl_q        <= 1'b1;
      sda_q        <= 1'b1;
      gpio_sync1_q <= '0;
      gpio_sync2_q <= '0;
    end
    else
    begin
      scl_sync_q   <= {scl_sync_q[0], scl_i};
      sda_sync_q   <= {sda_sync_q[0], sda_i};
      scl_q        <= scl_sync_q[1];
      sda_q        <= sda_sync_q[1];
      gpio_sync1_q <= gpio_i;
      gpio_sync2_q <= gpio_sync1_q;
    end
  end

  assign scl_rise  = scl_sync_q[1] & ~scl_q;
  assign scl_fall  = ~scl_sync_q[1] & scl_q;
  assign start_det = scl_sync_q[1] & scl_q & sda_q & ~sda_sync_q[1];
  assign stop_det  = scl_sync_q[1] & scl_q & ~sda_q & sda_sync_q[1];

  always_comb
  begin
    state_d   = state_q;
    bit_cnt_d = bit_cnt_q;
    shift_d   = shift_q;
    index_d   = index_q;
    ack_drv_d = ack_drv_q;
    tx_bit_d  = tx_bit_q;
    busy_d    = busy_q;
    wr_en     = 1'b0;
    if (start_det)
    begin
      busy_d    = 1'b1;
      state_d   = ST_ADDR;
      bit_cnt_d = 4'h0;
      ack_drv_d = 1'b0;
      tx_bit_d  = 1'b1;
    end
    else if (stop_det)
    begin
      busy_d    = 1'b0;
      state_d   = ST_IDLE;
      ack_drv_d = 1'b0;
      tx_bit_d  = 1'b1;
    end
    else
    begin
      case (state_q)
        ST_ADDR, ST_INDEX, ST_WDATA:
        begin
          if (scl_rise)
          begin
            shift_d   = {shift_q[6:0], sda_q};
            bit_cnt_d = bit_cnt_q + 4'h1;
          end
          // Drive ack on falling edge after eighth bit
          if (scl_fall && bit_cnt_q == 4'h8)
          begin
            bit_cnt_d = 4'h0;
            if (state_q == ST_ADDR)
            begin
              if (shift_q[7:1] == `SLAVE_ADDR)
              begin
                ack_drv_d = 1'b1;
                state_d   = ST_AACK;
              end
              else
              begin
                state_d = ST_IDLE;
              end
            end
            else
            begin
              ack_drv_d = 1'b1;
              state_d   = ST_DACK;
            end
          end
        end
        ST_AACK:
        begin
          if (scl_fall)
          begin
            ack_drv_d = 1'b0;
            if (shift_q[0])
            begin
              state_d  = ST_RDATA;
              tx_bit_d = rd_data[7];
              bit_cnt_d = 4'h1;
              shift_d  = {rd_data[6:0], 1'b0};
            end
            else
            begin
              state_d = ST_INDEX;
            end
          end
        end
        ST_DACK:
        begin
          // Further data bytes rewrite the same index
          if (scl_fall)
          begin
            ack_drv_d = 1'b0;
            state_d   = ST_WDATA;
          end
        end
        ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_q == 4'h8)
            begin
              tx_bit_d = 1'b1;
              state_d  = ST_RACK;
            end
            else
            begin
              tx_bit_d  = shift_q[7];
              shift_d   = {shift_q[6:0], 1'b0};
              bit_cnt_d = bit_cnt_q + 4'h1;
            end
          end
        end
        ST_RACK:
        begin
          if (scl_rise && sda_q)
          begin
            state_d = ST_IDLE;
          end
          else if (scl_rise)
          begin
            state_d   = ST_RDATA;
            bit_cnt_d = 4'h0;
            shift_d   = rd_data;
          end
        end
        default:
        begin
          state_d = ST_IDLE;
        end
      endcase
    end
    if (state_q == ST_DACK && scl_rise && !start_det && !stop_det)
    begin
      if (phase_q)
      begin
        wr_en = 1'b1;
      end
      else
      begin
        index_d = shift_q;
      end
    end
  end

  // Index byte versus data byte within a write
  always_comb
  begin
    phase_d = phase_q;
    if (start_det || stop_det)
    begin
      phase_d = 1'b0;
    end
    else if (state_q == ST_DACK && scl_fall)
    begin
      phase_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      index_q   <= 8'h00;
      ack_drv_q <= 1'b0;
      tx_bit_q  <= 1'b1;
      busy_q    <= 1'b0;
      phase_q   <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q   <= shift_d;
      index_q   <= index_d;
      ack_drv_q <= ack_drv_d;
      tx_bit_q  <= tx_bit_d;
      busy_q    <= busy_d;
      phase_q   <= phase_d;
    end
  end

  reg_store u_reg_store (
    .clk_sys_i     (clk_sys_i),
    .rst_b_i       (rst_b_i),
    .wr_en_i       (wr_en),
    .wr_index_i    (index_q),
    .wr_data_i     (shift_q),
    .rd_index_i    (index_q),
    .pin_state_i   (gpio_sync2_q),
    .rd_data_o     (rd_data),
    .pin_control_o (pin_control),
    .pin_data_o    (pin_data)
  );

  // Pin drivers, one per pin
  genvar g;
  generate
    for (g = 0; g < `PIN_COUNT; g++)
    begin : g_pin
      if (g == 0)
      begin : g_pwm
        assign oe_d[g] = pin_control[g] & ~pin_control[`PWM_EN_BIT];
      end
      else
      begin : g_plain
        assign oe_d[g] = pin_control[g];
      end
      assign out_d[g] = pin_data[g];
    end
  endgenerate

  assign pwm_d = pin_control[`PWM_EN_BIT] & gpio_sync2_q[0];

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      oe_q  <= '0;
      out_q <= '0;
      pwm_q <= 1'b0;
    end
    else
    begin
      oe_q  <= oe_d;
      out_q <= out_d;
      pwm_q <= pwm_d;
    end
  end

  // Open drain: drive low for ack or a zero data bit
  always_comb
  begin
    sda_o      = 1'b0;
    sda_oe_b_o = ~(ack_drv_q | (state_q == ST_RDATA && !tx_bit_q));
  end

  assign gpio_o      = out_q;
  assign gpio_oe_b_o = ~oe_q;
  assign pwm_in_o    = pwm_q;
  assign bus_busy_o  = busy_q;
endmodule // i2c_slave_gpio_regs

// >>> common/gpio_i2c_map.svh
`ifndef GPIO_I2C_MAP_SVH
`define GPIO_I2C_MAP_SVH
`define SLAVE_ADDR        7'h59
`define REG_PIN_CONTROL   8'h06
`define REG_PIN_DATA      8'h07
`define PWM_EN_BIT        4
`define PIN_COUNT         3
`define PIN_CONTROL_RESET 8'h00
`define PIN_DATA_RESET    8'h00
`define REG_COUNT         2
`endif

// >>> common/gpio_i2c_pkg.sv
package gpio_i2c_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_AACK  = 3'b011,
    ST_INDEX = 3'b010,
    ST_WDATA = 3'b110,
    ST_DACK  = 3'b111,
    ST_RDATA = 3'b101,
    ST_RACK  = 3'b100
  } slave_state_e;
  typedef logic [7:0] byte_t;
endpackage

// >>> rtl/reg_store.sv
`timescale 1ns/1ps
`include "gpio_i2c_map.svh"
module reg_store
  import gpio_i2c_pkg::*;
(
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_b_i,
  input  wire logic                    wr_en_i,
  input  wire byte_t                   wr_index_i,
  input  wire byte_t                   wr_data_i,
  input  wire byte_t                   rd_index_i,
  input  wire logic [`PIN_COUNT-1:0]   pin_state_i,
  output byte_t                        rd_data_o,
  output byte_t                        pin_control_o,
  output byte_t                        pin_data_o
);
  byte_t ctl_q, ctl_d, dat_q, dat_d, rd_q, rd_d;

  always_comb
  begin
    ctl_d = ctl_q;
    dat_d = dat_q;
    if (wr_en_i && wr_index_i == `REG_PIN_CONTROL)
    begin
      ctl_d = wr_data_i & 8'h17;
    end
    if (wr_en_i && wr_index_i == `REG_PIN_DATA)
    begin
      dat_d = wr_data_i & 8'h07;
    end
    rd_d = 8'h00;
    case (rd_index_i)
      `REG_PIN_CONTROL: rd_d = ctl_q;
      `REG_PIN_DATA:    rd_d = {5'h00, pin_state_i};
      default:          rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      ctl_q <= `PIN_CONTROL_RESET;
      dat_q <= `PIN_DATA_RESET;
      rd_q  <= 8'h00;
    end
    else
    begin
      ctl_q <= ctl_d;
      dat_q <= dat_d;
      rd_q  <= rd_d;
    end
  end

  assign rd_data_o     = rd_q;
  assign pin_control_o = ctl_q;
  assign pin_data_o    = dat_q;
endmodule // reg_store

// >>> tb/i2c_gpio_checker.sv
`timescale 1ns/1ps
`include "gpio_i2c_map.svh"
module i2c_gpio_checker
  import gpio_i2c_pkg::*;
(
  input wire logic                  clk_sys_i,
  input wire logic                  rst_b_i,
  input wire logic                  scl_i,
  input wire logic                  sda_i,
  input wire logic                  sda_o,
  input wire logic                  sda_oe_b_o,
  input wire logic [`PIN_COUNT-1:0] gpio_i,
  input wire logic [`PIN_COUNT-1:0] gpio_o,
  input wire logic [`PIN_COUNT-1:0] gpio_oe_b_o,
  input wire logic                  pwm_in_o,
  input wire logic                  bus_busy_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  chk_open_drain: assert property (!sda_oe_b_o |-> !sda_o)
    else $error("SDA driven high");
  chk_start_busy: assert property ($fell(sda_i) && scl_i |-> ##[1:8] bus_busy_o)
    else $error("START not seen");
  chk_stop_free: assert property ($rose(sda_i) && scl_i |-> ##[1:8] !bus_busy_o)
    else $error("STOP not seen");
  chk_sda_low_phase: assert property ($changed(sda_oe_b_o) |-> !scl_i)
    else $error("SDA drive moved while SCL high");
  chk_pwm_pin0: assert property (pwm_in_o |-> gpio_oe_b_o[0])
    else $error("PWM input while pin 0 driven");
  chk_dir_commit: assert property ($changed(gpio_oe_b_o) |-> !sda_oe_b_o)
    else $error("Direction changed outside ack");
  chk_data_commit: assert property ($changed(gpio_o) |-> !sda_oe_b_o)
    else $error("Pin data changed outside ack");
  chk_free_released: assert property (!bus_busy_o |-> sda_oe_b_o)
    else $error("SDA driven on free bus");
  cover property ($fell(sda_oe_b_o));
  cover property ($rose(pwm_in_o));
  cover property ($changed(gpio_o));
endmodule // i2c_gpio_checker

bind i2c_slave_gpio_regs i2c_gpio_checker u_chk (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_b_o(sda_oe_b_o), .gpio_i(gpio_i),
  .gpio_o(gpio_o), .gpio_oe_b_o(gpio_oe_b_o), .pwm_in_o(pwm_in_o), .bus_busy_o(bus_busy_o));

// >>> tb/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
  output logic      scl_o,
  output logic      sda_o,
  input  wire logic sda_i
);
  // Four system clocks per phase: 160 ns link period
  localparam int PH = 80;
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic start();
    #(PH/2) sda_o = 1'b1;
    #(PH/2) scl_o = 1'b1;
    #(PH/2) sda_o = 1'b0;
    #(PH/2) scl_o = 1'b0;
  endtask
  task automatic stop();
    #(PH/2) sda_o = 1'b0;
    #(PH/2) scl_o = 1'b1;
    #(PH/2) sda_o = 1'b1;
    #PH;
  endtask
  // Eight bits then the acknowledge slot
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      #(PH/2) sda_o = tx[i];
      #(PH/2) scl_o = 1'b1;
      #(PH-1) rx[i] = sda_i;
      #1 scl_o = 1'b0;
    end
  endtask
endmodule // i2c_master_model

// >>> tb/tb.sv
`timescale 1ns/1ps
`include "gpio_i2c_map.svh"
module tb
  import gpio_i2c_pkg::*;
;
  logic                  clk_sys_i;
  logic                  rst_b_i;
  logic                  m_scl;
  logic                  m_sda;
  logic                  sda_o;
  logic                  sda_oe_b_o;
  logic                  sda;
  logic [`PIN_COUNT-1:0] ext;
  logic [`PIN_COUNT-1:0] pin;
  logic [`PIN_COUNT-1:0] gpio_o;
  logic [`PIN_COUNT-1:0] gpio_oe_b_o;
  logic                  pwm_in_o;
  logic                  bus_busy_o;
  logic [8:0]            rx;
  int                    failures;
  int                    check_count;
  // Pull-up on SDA; pins resolve per output enable
  assign sda = m_sda & (sda_oe_b_o | sda_o);
  assign pin = (gpio_oe_b_o & ext) | (~gpio_oe_b_o & gpio_o);
  i2c_slave_gpio_regs DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .scl_i(m_scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_b_o(sda_oe_b_o), .gpio_i(pin), .gpio_o(gpio_o),
    .gpio_oe_b_o(gpio_oe_b_o), .pwm_in_o(pwm_in_o), .bus_busy_o(bus_busy_o));
  i2c_master_model m (.scl_o(m_scl), .sda_o(m_sda), .sda_i(sda));
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic send(input byte_t b);
    m.xfer({b, 1'b1}, rx);
    check("ack", {7'h0, rx[0]}, 8'h00);
  endtask
  task automatic wr(input byte_t i, input byte_t d);
    m.start();
    send({`SLAVE_ADDR, 1'b0});
    send(i);
    send(d);
    m.stop();
  endtask
  task automatic rd(input byte_t i, input byte_t e, input string n);
    m.start();
    send({`SLAVE_ADDR, 1'b0});
    send(i);
    m.start();
    send({`SLAVE_ADDR, 1'b1});
    m.xfer(9'h1ff, rx);
    m.stop();
    check(n, rx[8:1], e);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  initial
  begin
    #1ms;
    failures++;
    final_report();
  end
  initial
  begin
    rst_b_i = 1'b0;
    ext = 3'h5;
    failures = 0;
    check_count = 0;
    repeat (2) @(negedge clk_sys_i);
    rst_b_i = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    check("oe", {5'h0, gpio_oe_b_o}, 8'h07);
    check("busy", {7'h0, bus_busy_o}, 8'h00);
    rd(`REG_PIN_CONTROL, `PIN_CONTROL_RESET, "ctl");
    rd(`REG_PIN_DATA, 8'h05, "din");
    wr(`REG_PIN_CONTROL, 8'h07);
    wr(`REG_PIN_DATA, 8'h02);
    check("oe", {5'h0, gpio_oe_b_o}, 8'h00);
    check("out", {5'h0, gpio_o}, 8'h02);
    rd(`REG_PIN_DATA, 8'h02, "dout");
    m.start();
    m.xfer(9'h161, rx);
    check("nack", {7'h0, rx[0]}, 8'h01);
    check("busy", {7'h0, bus_busy_o}, 8'h01);
    wr(`REG_PIN_DATA, 8'h04);
    check("out", {5'h0, gpio_o}, 8'h04);
    check("busy", {7'h0, bus_busy_o}, 8'h00);
    wr(8'h08, 8'hff);
    rd(8'h08, 8'h00, "unmap");
    check("out", {5'h0, gpio_o}, 8'h04);
    wr(`REG_PIN_CONTROL, 8'h15);
    check("oe", {5'h0, gpio_oe_b_o}, 8'h03);
    repeat (8) @(negedge clk_sys_i);
    check("pwm", {7'h0, pwm_in_o}, 8'h01);
    ext = 3'h0;
    repeat (8) @(negedge clk_sys_i);
    check("pwm", {7'h0, pwm_in_o}, 8'h00);
    // Write lands at the data ack, before STOP
    m.start();
    send({`SLAVE_ADDR, 1'b0});
    send(`REG_PIN_DATA);
    send(8'h06);
    check("commit", {5'h0, gpio_o}, 8'h06);
    check("busy", {7'h0, bus_busy_o}, 8'h01);
    send(8'h03);
    check("rewrite", {5'h0, gpio_o}, 8'h03);
    m.stop();
    rd(`REG_PIN_CONTROL, 8'h15, "ctl");
    final_report();
  end
endmodule // tb
